/* File: sacr_adc_control.v */
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "sacr_defs.vh"
// Contract
// - Interrupts off: done flag sets per conversion, clears on result read.
// - Interrupts on: done flag never sets and reads zero.
// - Interrupts on: request per conversion; result read or control write clears.
// - Continuous mode repeats conversions; otherwise one per control write.
// - Select codes zero to seven pick analog inputs zero to seven.
// - Codes 11101 and 11110 route upper and lower references.
// - All-ones select powers the converter off.
// - Reserved select codes give an undefined result.
// - One 8-bit result register loads on every completed conversion.
// - Divider codes pick divide by 1, 2, 4, 8 or 16.
// - Source bit picks bus clock at one, oscillator at zero.
// - Any control register write starts a conversion, except one with the all-ones power-off select.
// - A conversion takes 16 to 17 converter clocks.
// - Stop mode aborts conversion and holds the converter inactive.
module sacr_adc_control (
  input wire core_clk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire bus_clk_en,
  input wire osc_clk_en,
  input wire stop_mode,
  input wire comparator_high,
  output wire [7:0] trial_code,
  output wire sample_enable,
  output reg [7:0] analog_input_enable,
  output reg upper_reference_select,
  output reg lower_reference_select,
  output reg converter_power_on,
  output reg adc_irq,
  output reg irq
);
  reg conversion_done_flag;
  reg done_irq_enable;
  reg continuous_mode;
  reg [4:0] input_select;
  reg clock_source_select;
  reg [2:0] clock_divider;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg start_pending;
  wire conv_tick;
  wire busy;
  wire done;
  wire sampling;
  wire [7:0] result;
  wire access;
  wire wr;
  wire rd;
  wire wr_ctrl;
  wire rd_result;
  wire powered;
  wire start;
  wire valid_addr;
  // Clock register reset image, split into its fields below
  localparam [7:0] RST_CLOCK = `SACR_RST_CLOCK;

  // Full byte address compare shared by every decode
  function is_reg;
    input [11:0] addr;
    input [11:0] off;
    begin
      is_reg = (addr == off);
    end
  endfunction

  assign access = psel & penable;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign pready = 1'b1;
  assign valid_addr = is_reg(paddr, `SACR_OFF_STATUS_CONTROL) |
    is_reg(paddr, `SACR_OFF_RESULT) | is_reg(paddr, `SACR_OFF_CLOCK_CONFIG) |
    is_reg(paddr, `SACR_OFF_IRQ_STATUS) | is_reg(paddr, `SACR_OFF_IRQ_MASK);
  // Unmapped addresses answer with an error, no side effects
  assign pslverr = access & ~valid_addr;
  assign wr_ctrl = wr & is_reg(paddr, `SACR_OFF_STATUS_CONTROL);
  assign rd_result = rd & is_reg(paddr, `SACR_OFF_RESULT);
  assign powered = (input_select != `SACR_SEL_POWER_OFF);
  assign sample_enable = sampling;

  sacr_clock_divider u_div (
    .core_clk(core_clk),
    .reset(reset),
    .bus_clk_en(bus_clk_en),
    .osc_clk_en(osc_clk_en),
    .clock_source_select(clock_source_select),
    .clock_divider(clock_divider),
    .conv_tick(conv_tick)
  );

  // Start on a control write, or back to back in continuous mode
  assign start = start_pending & powered & ~stop_mode & conv_tick;

  sacr_sar_engine u_sar (
    .core_clk(core_clk),
    .reset(reset),
    .conv_tick(conv_tick),
    .start(start),
    .abort(stop_mode | ~powered),
    .comparator_high(comparator_high),
    .trial_code(trial_code),
    .sampling(sampling),
    .busy(busy),
    .done(done),
    .result(result)
  );

  // Control register, start request and done flag
  always @(posedge core_clk) begin
    if (reset) begin
      conversion_done_flag <= 1'b0;
      done_irq_enable <= 1'b0;
      continuous_mode <= 1'b0;
      input_select <= `SACR_RST_SEL;
      clock_source_select <= RST_CLOCK[`SACR_BIT_CLK_SRC];
      clock_divider <= RST_CLOCK[`SACR_DIV_MSB:`SACR_DIV_LSB];
      start_pending <= 1'b0;
      adc_irq <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        // Done bit of the write data is ignored; software keeps it zero
        done_irq_enable <= pwdata[`SACR_BIT_IRQ_EN];
        continuous_mode <= pwdata[`SACR_BIT_CONT];
        input_select <= pwdata[`SACR_SEL_MSB:`SACR_SEL_LSB];
        start_pending <= 1'b1;
      end else if (start) begin
        start_pending <= 1'b0;
      end else if (done & continuous_mode) begin
        start_pending <= 1'b1;
      end
      if (wr & is_reg(paddr, `SACR_OFF_CLOCK_CONFIG)) begin
        clock_source_select <= pwdata[`SACR_BIT_CLK_SRC];
        clock_divider <= pwdata[`SACR_DIV_MSB:`SACR_DIV_LSB];
      end
      // Completion wins over a clearing read in the same cycle
      if (done & ~done_irq_enable)
        conversion_done_flag <= 1'b1;
      else if (rd_result | done_irq_enable)
        conversion_done_flag <= 1'b0;
      if (done & done_irq_enable)
        adc_irq <= 1'b1;
      else if (rd_result | wr_ctrl)
        adc_irq <= 1'b0;
    end
  end

  // Sticky events: bit0 conversion done, bit1 aborted by stop mode
  always @(posedge core_clk) begin
    if (reset) begin
      irq_status <= 2'b00;
      irq_mask <= 2'b00;
      irq <= 1'b0;
    end else begin
      if (wr & is_reg(paddr, `SACR_OFF_IRQ_MASK))
        irq_mask <= pwdata[1:0];
      irq_status <= (irq_status &
        ~((wr & is_reg(paddr, `SACR_OFF_IRQ_STATUS)) ? pwdata[1:0] : 2'b00))
        | {stop_mode & busy, done};
      irq <= |(irq_status & irq_mask);
    end
  end

  // Analog routing; reserved codes enable nothing, result is undefined
  always @(posedge core_clk) begin
    if (reset) begin
      analog_input_enable <= 8'h00;
      upper_reference_select <= 1'b0;
      lower_reference_select <= 1'b0;
      converter_power_on <= 1'b0;
    end else begin
      analog_input_enable <= (input_select[4:3] == 2'b00) ?
        (8'h01 << input_select[2:0]) : 8'h00;
      upper_reference_select <= (input_select == `SACR_SEL_REF_HIGH);
      lower_reference_select <= (input_select == `SACR_SEL_REF_LOW);
      // Stop mode drops power too, so the next start needs settling
      converter_power_on <= powered & ~stop_mode;
    end
  end
  // reserved codes still convert; the comparator input is undriven

  // Read mux, registered data output
  always @(posedge core_clk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= 32'h0000_0000;
      if (is_reg(paddr, `SACR_OFF_STATUS_CONTROL))
        prdata[7:0] <= {conversion_done_flag & ~done_irq_enable,
          done_irq_enable, continuous_mode, input_select};
      else if (is_reg(paddr, `SACR_OFF_RESULT))
        prdata[7:0] <= result;
      else if (is_reg(paddr, `SACR_OFF_CLOCK_CONFIG))
        prdata[7:0] <= {clock_divider, clock_source_select, 4'h0};
      else if (is_reg(paddr, `SACR_OFF_IRQ_STATUS))
        prdata[1:0] <= irq_status;
      else if (is_reg(paddr, `SACR_OFF_IRQ_MASK))
        prdata[1:0] <= irq_mask;
    end
  end
endmodule // sacr_adc_control

/* File: sacr_analog_model.sv */
`timescale 1ns/1ps
// Analog side: input mux plus comparator against the trial code
module sacr_analog_model (
  input wire logic core_clk,
  input wire logic [63:0] levels,
  input wire logic [7:0] analog_input_enable,
  input wire logic upper_reference_select,
  input wire logic lower_reference_select,
  input wire logic converter_power_on,
  input wire logic [7:0] trial_code,
  output wire comparator_high
);
  logic [7:0] vin;
  logic tgl = 1'b0;
  // Unpowered comparator wanders, so a held level proves nothing
  always @(posedge core_clk) tgl <= ~tgl;
  // Mux picks the channel or a reference
  always_comb begin
    vin = 8'h00;
    for (int i = 0; i < 8; i++)
      if (analog_input_enable[i]) vin = levels[8*i +: 8];
    if (upper_reference_select) vin = 8'hFF;
    if (lower_reference_select) vin = 8'h00;
  end
  assign comparator_high = converter_power_on ? vin >= trial_code : tgl;
endmodule // sacr_analog_model

/* File: sacr_clock_divider.v */
`timescale 1ns/1ps
// Converter clock enable: source pick then divide by 1,2,4,8,16
module sacr_clock_divider (
  input wire core_clk,
  input wire reset,
  input wire bus_clk_en,
  input wire osc_clk_en,
  input wire clock_source_select,
  input wire [2:0] clock_divider,
  output reg conv_tick
);
  reg [3:0] count;
  wire src_en;
  reg [3:0] limit;

  assign src_en = clock_source_select ? bus_clk_en : osc_clk_en;

  // Terminal count per divider code; any top-bit code means 16
  always @* begin
    case (clock_divider)
      3'b000: limit = 4'h0;
      3'b001: limit = 4'h1;
      3'b010: limit = 4'h3;
      3'b011: limit = 4'h7;
      default: limit = 4'hF;
    endcase
  end

  // Counts source enables; restart on reset only so ratio changes settle
  always @(posedge core_clk) begin
    if (reset) begin
      count <= 4'h0;
      conv_tick <= 1'b0;
    end else begin
      conv_tick <= 1'b0;
      if (src_en) begin
        if (count >= limit) begin
          count <= 4'h0;
          conv_tick <= 1'b1;
        end else begin
          count <= count + 4'h1;
        end
      end
    end
  end
endmodule // sacr_clock_divider

/* File: sacr_defs.vh */
`ifndef SACR_DEFS_VH
`define SACR_DEFS_VH
// Register byte addresses on the APB
`define SACR_OFF_STATUS_CONTROL 12'h000
`define SACR_OFF_RESULT 12'h004
`define SACR_OFF_CLOCK_CONFIG 12'h008
`define SACR_OFF_IRQ_STATUS 12'h00C
`define SACR_OFF_IRQ_MASK 12'h010
// Status and control field positions
`define SACR_BIT_DONE 7
`define SACR_BIT_IRQ_EN 6
`define SACR_BIT_CONT 5
`define SACR_SEL_MSB 4
`define SACR_SEL_LSB 0
// Clock config field positions
`define SACR_BIT_CLK_SRC 4
`define SACR_DIV_MSB 7
`define SACR_DIV_LSB 5
// Reset values
`define SACR_RST_SEL 5'h1F
`define SACR_RST_CLOCK 8'h00
// Input select codes
`define SACR_SEL_REF_HIGH 5'h1D
`define SACR_SEL_REF_LOW 5'h1E
`define SACR_SEL_POWER_OFF 5'h1F
// Trial steps per conversion, after an 8-tick sample phase
`define SACR_CONV_BITS 8
`endif

/* File: sacr_props_properties.sv */
`timescale 1ns/1ps
// Port-level checks on the converter control block
module sacr_props (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic stop_mode,
  input wire logic sample_enable,
  input wire logic [7:0] analog_input_enable,
  input wire logic upper_reference_select,
  input wire logic lower_reference_select,
  input wire logic converter_power_on,
  input wire logic adc_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Completed bus transfers to the control and result registers
  sequence ctrl_wr;
    psel && penable && pwrite && paddr == 12'h000;
  endsequence
  sequence ctrl_rd;
    psel && penable && !pwrite && paddr == 12'h000;
  endsequence
  sequence res_rd;
    psel && penable && !pwrite && paddr == 12'h004;
  endsequence
  a_ctrl_write_irq: assert property (ctrl_wr |=> !adc_irq)
    else $error("irq kept after control write");
  a_read_clears_irq: assert property (res_rd |=> !adc_irq)
    else $error("irq kept after result read");
  a_done_hidden: assert property (ctrl_rd and prdata[6] |-> !prdata[7])
    else $error("done flag seen with irq enabled");
  // Bound of 200 cycles leaves wide margin over the wait for one divide by 16 tick
  a_write_starts: assert property (ctrl_wr and pwdata[4:3] == 2'h0 &&
    !stop_mode |-> ##[1:200] sample_enable)
    else $error("no conversion after control write");
  a_power_off_sel: assert property (ctrl_wr and pwdata[4:0] == 5'h1F
    |-> ##2 !converter_power_on)
    else $error("converter still powered");
  a_off_no_sample: assert property (!converter_power_on [*3]
    |-> !sample_enable)
    else $error("sampling while off");
  a_stop_halts: assert property (stop_mode [*2]
    |-> !converter_power_on && !sample_enable)
    else $error("converter active in stop");
  a_input_onehot: assert property ($onehot0(analog_input_enable))
    else $error("several inputs enabled");
  a_refs_apart: assert property ($onehot0({upper_reference_select,
    lower_reference_select, analog_input_enable}))
    else $error("reference overlaps an input");
endmodule // sacr_props

/* File: sacr_sar_engine.v */
`timescale 1ns/1ps
`include "sacr_defs.vh"
// Successive approximation sequencer, one step per converter tick
module sacr_sar_engine (
  input wire core_clk,
  input wire reset,
  input wire conv_tick,
  input wire start,
  input wire abort,
  input wire comparator_high,
  output reg [7:0] trial_code,
  output reg sampling,
  output reg busy,
  output reg done,
  output reg [7:0] result
);
  localparam ST_IDLE = 3'b001;
  localparam ST_SAMPLE = 3'b010;
  localparam ST_RESOLVE = 3'b100;
  reg [2:0] state;
  reg [7:0] bit_mask;
  reg [3:0] hold;

  // One sample phase of 8 ticks, then 8 decisions: 16 ticks, 17 with
  // start alignment against the free-running tick
  always @(posedge core_clk) begin
    if (reset || abort) begin
      state <= ST_IDLE;
      trial_code <= 8'h00;
      bit_mask <= 8'h00;
      hold <= 4'h0;
      sampling <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      if (reset)
        result <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start) begin
        state <= ST_SAMPLE;
        hold <= 4'h0;
        sampling <= 1'b1;
        busy <= 1'b1;
        trial_code <= 8'h00;
      end else if (conv_tick) begin
        case (state)
          ST_SAMPLE: begin
            if (hold == 4'h7) begin
              state <= ST_RESOLVE;
              sampling <= 1'b0;
              trial_code <= 8'h80;
              bit_mask <= 8'h80;
            end else begin
              hold <= hold + 4'h1;
            end
          end
          ST_RESOLVE: begin
            // Keep or drop current bit, then try the next one down
            if (bit_mask == 8'h01) begin
              result <= comparator_high ? trial_code :
                (trial_code & ~bit_mask);
              done <= 1'b1;
              busy <= 1'b0;
              state <= ST_IDLE;
            end else begin
              trial_code <= (comparator_high ? trial_code :
                (trial_code & ~bit_mask)) | (bit_mask >> 1);
              bit_mask <= bit_mask >> 1;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // sacr_sar_engine

/* File: tb.sv */
`timescale 1ns/1ps
// Converter control bench, all traffic over APB
module tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic bus_clk_en = 1'b1;
  logic osc_clk_en = 1'b0;
  logic stop_mode = 1'b0;
  logic [63:0] levels = 64'hF0C3_A55A_3C81_7E12;
  wire pready, pslverr, comparator_high, sample_enable, irq, adc_irq;
  wire upper_reference_select, lower_reference_select, converter_power_on;
  wire [31:0] prdata;
  wire [7:0] trial_code, analog_input_enable;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int num_checks = 0;
  int cyc;
  logic [7:0] cfg [7] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hF0, 8'h00};
  int dv [7] = '{1, 2, 4, 8, 16, 16, 2};
  logic [7:0] fsel [3] = '{8'h1D, 8'h1E, 8'h00};
  logic [7:0] fexp [3] = '{8'hFF, 8'h00, 8'h12};
  sacr_adc_control DUT (.*);
  sacr_analog_model u_analog (.*);
  always #2.5 core_clk = ~core_clk;
  // Oscillator at half rate, so the source choice shows in the timing
  always @(posedge core_clk) osc_clk_en <= ~osc_clk_en;
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error kept in rd and err
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this step
    @(posedge core_clk);
  endtask
  // Polls the done flag with a bounded number of reads
  task automatic conv_wait();
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[7] !== 1'b1) begin
      apb(1'b0, 12'h000, 32'h0);
      n++;
      if (n > 200) begin
        num_errors++;
        final_report();
      end
    end
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h1F);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0);
    // Throwaway conversion lets the converter settle after power-up
    apb(1'b1, 12'h000, 32'h0);
    conv_wait();
    apb(1'b0, 12'h004, 32'h0);
    $display("reset test done");
    // Interrupt mode over every divider and both sources
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, 12'h008, {24'h0, cfg[i]});
      apb(1'b1, 12'h000, 32'h40 + 32'(i));
      cyc = 0;
      while (adc_irq !== 1'b1 && cyc < 3000) begin
        @(posedge core_clk);
        cyc++;
      end
      chk(32'(cyc >= 16 * dv[i] && cyc <= 18 * dv[i] + 4), 32'h1);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h40 + 32'(i));
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, {24'h0, levels[8*i +: 8]});
      @(posedge core_clk);
      chk(32'(adc_irq), 32'h0);
    end
    chk(32'(irq), 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, 12'h010, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h1);
    apb(1'b1, 12'h00C, 32'h1);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0);
    $display("interrupt test done");
    // Flag mode on both references and one channel
    apb(1'b1, 12'h008, 32'h10);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 12'h000, {24'h0, fsel[i]});
      conv_wait();
      chk(rd, 32'h80 + {24'h0, fsel[i]});
      apb(1'b0, 12'h004, 32'h0);
      chk(rd, {24'h0, fexp[i]});
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, {24'h0, fsel[i]});
    end
    $display("flag test done");
    // Continuous mode follows a changed input
    apb(1'b1, 12'h000, 32'h23);
    conv_wait();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h3C);
    levels <= ~levels;
    conv_wait();
    apb(1'b0, 12'h004, 32'h0);
    conv_wait();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'hC3);
    apb(1'b1, 12'h000, 32'h1F);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'hC3);
    chk(32'(converter_power_on), 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    $display("continuous test done");
    // Stop mode blocks the conversion
    stop_mode <= 1'b1;
    apb(1'b1, 12'h000, 32'h40);
    repeat (100) @(posedge core_clk);
    chk(32'(adc_irq), 32'h0);
    chk(32'(converter_power_on), 32'h0);
    stop_mode <= 1'b0;
    $display("stop test done");
    final_report();
  end
endmodule // tb
bind sacr_adc_control sacr_props u_props (.*);
